/* ris_map.svh */
// Register map, reset values, mode write mask and prescaler count of the input selector
`ifndef RIS_MAP_SVH
`define RIS_MAP_SVH
`define RIS_IDX_INPUT_PRIORITY      6'h14
`define RIS_IDX_MODE      6'h15
`define RIS_IDX_HOLD      6'h16
`define RIS_IDX_DIVPWR    6'h17
`define RIS_IDX_STATUS    6'h18
`define RIS_RST_INPUT_PRIORITY      8'he4
`define RIS_RST_MODE      8'h00
`define RIS_RST_HOLD      8'h80
`define RIS_RST_DIVPWR    8'h80
`define RIS_MODE_MASK     8'h7f
`define RIS_PRESCALE_DIV4 2'h3
`endif

/* ris_pkg.sv */
// Types and shared ranking function of the input selector
package ris_pkg;
    typedef enum logic [1:0] {
        RIS_ST_TRACK = 2'h0,
        RIS_ST_WAIT  = 2'h1,
        RIS_ST_NOREF = 2'h3
    } ris_state_t;

    typedef struct packed {
        logic       reserved;
        logic       loss_of_reference_block;
        logic       monitor_prescale_select;
        logic       revertive_switch_enable;
        logic [1:0] selection_mode_field;
        logic [1:0] manual_select;
    } ris_ctrl_t;

    // Rank = priority, then lower input index wins ties
    function automatic logic [3:0] ris_rank(input logic [7:0] input_priority,
                                            input logic [1:0] idx);
        logic [1:0] p;
        p = 2'h0;
        case (idx)
            2'h0:    p = input_priority[7:6];
            2'h1:    p = input_priority[5:4];
            2'h2:    p = input_priority[3:2];
            default: p = input_priority[1:0];
        endcase
        return {p, ~idx};
    endfunction : ris_rank
endpackage : ris_pkg

/* ris_best_pick.sv */
// Picks the highest ranked input that has no loss of signal
`timescale 1ns/10ps
module ris_best_pick import ris_pkg::*; (
    input  wire logic [7:0] input_priority,
    input  wire logic [3:0] los,
    output logic      [1:0] best,
    output logic            any_valid
);
    logic [3:0] r [4];
    logic [1:0] b01;
    logic [1:0] b23;
    logic       v01;
    logic       v23;

    // Index order breaks priority ties
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            r[i] = ris_rank(input_priority, 2'(i));
        end
    end

    assign v01 = ~los[0] | ~los[1];
    assign v23 = ~los[2] | ~los[3];
    assign b01 = (los[0] | (~los[1] & r[1] > r[0])) ? 2'h1 : 2'h0;
    assign b23 = (los[2] | (~los[3] & r[3] > r[2])) ? 2'h3 : 2'h2;
    assign best = (!v01 | (v23 & r[b23] > r[b01])) ? b23 : b01;
    assign any_valid = v01 | v23;
endmodule : ris_best_pick

/* ris_holdoff.sv */
// Hold-off down counter for automatic switching with holdover
`timescale 1ns/10ps
`include "ris_map.svh"
module ris_holdoff (
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic       arm,
    input  wire logic       tick,
    input  wire logic [7:0] load_val,
    output logic            expire
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_dec;
    assign cnt_dec = cnt_q - 8'h01;

    // Reload after each expiry keeps later fail-overs paced
    always_ff @(posedge clock) begin
        if (sys_rst || !arm) begin
            cnt_q  <= sys_rst ? `RIS_RST_HOLD : load_val;
            expire <= 1'b0;
        end else if (tick) begin
            expire <= (cnt_q == 8'h00) || (cnt_dec == 8'h00);
            cnt_q  <= (cnt_q == 8'h00 || cnt_dec == 8'h00) ? load_val
                                                            : cnt_dec;
        end else begin
            expire <= 1'b0;
        end
    end
endmodule : ris_holdoff

/* ris_selector.sv */
// Reference input selector with Avalon-MM register slave
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/10ps
`include "ris_map.svh"
module ris_selector import ris_pkg::*; (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [3:0]  los_in,
    input  wire logic        holdoff_tick,
    input  wire logic        monitor_tick,
    output logic             monitor_tick_out,
    output logic [1:0]       sel_idx_q,
    output logic             no_reference_q
);
    //------------------------------------------------------------------
    // Register slave
    //------------------------------------------------------------------
    logic [7:0]  input_priority_q;
    ris_ctrl_t   ctrl_q;
    logic [7:0]  hold_q;
    logic [7:0]  divpwr_q;
    ris_state_t  state_q;
    ris_state_t  state_d;
    logic [1:0]  sel_d;
    logic [3:0]  los_q;
    logic [1:0]  pre_cnt_q;
    logic [5:0]  word;
    logic        req;
    logic        wr_go;
    logic [7:0]  rd_mux;
    logic [7:0]  status;

    assign word   = avs_address[7:2];
    assign req    = avs_read | avs_write;
    assign wr_go  = avs_write & ~avs_waitrequest;
    assign status = {2'h0, state_q, los_in};
    assign rd_mux = (word == `RIS_IDX_INPUT_PRIORITY)   ? input_priority_q :
                    (word == `RIS_IDX_MODE)   ? ctrl_q :
                    (word == `RIS_IDX_HOLD)   ? hold_q :
                    (word == `RIS_IDX_DIVPWR) ? divpwr_q :
                    (word == `RIS_IDX_STATUS) ? status : 8'h00;

    // One wait cycle, then a one-cycle acknowledge
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0;
        end else begin
            avs_waitrequest <= ~(req & avs_waitrequest);
            avs_readdata    <= {24'h0, rd_mux};
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            input_priority_q   <= `RIS_RST_INPUT_PRIORITY;
            ctrl_q   <= `RIS_RST_MODE;
            hold_q   <= `RIS_RST_HOLD;
            divpwr_q <= `RIS_RST_DIVPWR;
        end else if (wr_go) begin
            if (word == `RIS_IDX_INPUT_PRIORITY)   input_priority_q   <= avs_writedata[7:0];
            if (word == `RIS_IDX_MODE)
                ctrl_q <= avs_writedata[7:0] & `RIS_MODE_MASK;
            if (word == `RIS_IDX_HOLD)   hold_q   <= avs_writedata[7:0];
            if (word == `RIS_IDX_DIVPWR) divpwr_q <= avs_writedata[7:0];
        end
    end

    //------------------------------------------------------------------
    // Monitor prescaler
    //------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pre_cnt_q        <= 2'h0;
            monitor_tick_out <= 1'b0;
        end else begin
            monitor_tick_out <= monitor_tick &
                (!ctrl_q.monitor_prescale_select
                 || pre_cnt_q == `RIS_PRESCALE_DIV4);
            if (monitor_tick) pre_cnt_q <= pre_cnt_q + 2'h1;
        end
    end

    //------------------------------------------------------------------
    // Selection state machine
    //------------------------------------------------------------------
    logic [1:0] best;
    logic       any_valid;
    logic       auto_mode;
    logic       cur_lost;
    logic       revert_ev;
    logic       outranks;
    logic       expire;
    logic       hold_mode;

    ris_best_pick u_pick (
        .input_priority      (input_priority_q),
        .los       (los_in),
        .best      (best),
        .any_valid (any_valid)
    );

    ris_holdoff u_hold (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .arm      (hold_mode & cur_lost & (state_q == RIS_ST_WAIT)),
        .tick     (holdoff_tick),
        .load_val (hold_q),
        .expire   (expire)
    );

    assign auto_mode = ctrl_q.selection_mode_field[0];
    assign hold_mode = ctrl_q.selection_mode_field == 2'h3;
    assign cur_lost  = los_in[sel_idx_q];
    // Recovery of an unselected input; rising edge of validity
    assign revert_ev = |(los_q & ~los_in & ~(4'h1 << sel_idx_q));
    assign outranks  = ris_rank(input_priority_q, best) > ris_rank(input_priority_q, sel_idx_q);

    always_comb begin
        state_d = state_q;
        sel_d   = sel_idx_q;
        if (!auto_mode) begin
            state_d = RIS_ST_TRACK;
            sel_d   = ctrl_q.manual_select;
        end else begin
            case (state_q)
                RIS_ST_TRACK: begin
                    if (cur_lost && hold_mode) begin
                        state_d = RIS_ST_WAIT;
                    end else if (cur_lost) begin
                        // Keep the old index rather than jump to a dead one
                        sel_d   = any_valid ? best : sel_idx_q;
                        state_d = any_valid ? RIS_ST_TRACK : RIS_ST_NOREF;
                    end else if (revert_ev && outranks
                                 && ctrl_q.revertive_switch_enable) begin
                        sel_d = best;
                    end
                end
                RIS_ST_WAIT: begin
                    if (!cur_lost) begin
                        state_d = RIS_ST_TRACK;
                    end else if (expire || !hold_mode) begin
                        sel_d   = any_valid ? best : sel_idx_q;
                        state_d = any_valid ? RIS_ST_TRACK : RIS_ST_NOREF;
                    end
                end
                RIS_ST_NOREF: begin
                    if (any_valid) begin
                        sel_d   = best;
                        state_d = RIS_ST_TRACK;
                    end
                end
                default: state_d = RIS_ST_TRACK;
            endcase
        end
    end

    // Index moves only on the clock edge so the mux never glitches
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_q        <= RIS_ST_TRACK;
            sel_idx_q      <= 2'h0;
            los_q          <= 4'h0;
            no_reference_q <= 1'b0;
        end else begin
            state_q        <= state_d;
            sel_idx_q      <= sel_d;
            los_q          <= los_in;
            no_reference_q <= state_d == RIS_ST_NOREF;
        end
    end

    //------------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------------
    sequence s_track_auto;
        auto_mode && state_q == RIS_ST_TRACK;
    endsequence

    sequence s_lost_hold;
        s_track_auto ##0 hold_mode && cur_lost;
    endsequence

    AST_INPUT_PRIORITY_RESET: assert property (@(posedge clock)
        sys_rst |=> input_priority_q == 8'he4)
        else $error("priority reset value wrong");

    AST_TIE_ORDER: assert property (@(posedge clock)
        disable iff (sys_rst)
        any_valid |-> !los_in[best] && (los_in[0]
            || ris_rank(input_priority_q, best) >= ris_rank(input_priority_q, 2'h0)))
        else $error("best input not highest ranked");

    AST_PRESCALE: assert property (@(posedge clock)
        disable iff (sys_rst)
        !ctrl_q.monitor_prescale_select && monitor_tick |=> monitor_tick_out)
        else $error("divide by one lost a tick");

    AST_MANUAL: assert property (@(posedge clock)
        disable iff (sys_rst)
        !auto_mode |=> sel_idx_q == $past(ctrl_q.manual_select))
        else $error("manual select not followed");

    AST_NO_REVERT: assert property (@(posedge clock)
        disable iff (sys_rst)
        s_track_auto ##0 !ctrl_q.revertive_switch_enable && !cur_lost
        |=> $stable(sel_idx_q))
        else $error("selection moved without revertive mode");

    AST_REVERT: assert property (@(posedge clock)
        disable iff (sys_rst)
        s_track_auto ##0 ctrl_q.revertive_switch_enable && !cur_lost
        && revert_ev && outranks |=> sel_idx_q == $past(best))
        else $error("revertive switch missed");

    AST_AUTO_FAIL: assert property (@(posedge clock)
        disable iff (sys_rst)
        s_track_auto ##0 !hold_mode && cur_lost && any_valid
        |=> sel_idx_q == $past(best) && state_q == RIS_ST_TRACK)
        else $error("automatic fail-over missed");

    AST_HOLDOFF: assert property (@(posedge clock)
        disable iff (sys_rst)
        s_lost_hold |=> state_q == RIS_ST_WAIT
        && sel_idx_q == $past(sel_idx_q))
        else $error("hold-off not entered");

    AST_CTRL_RESET: assert property (@(posedge clock)
        sys_rst |=> !ctrl_q.revertive_switch_enable
        && !ctrl_q.monitor_prescale_select && ctrl_q.manual_select == 2'h0)
        else $error("control reset value wrong");

    sequence s_wait_lost;
        auto_mode && state_q == RIS_ST_WAIT && cur_lost;
    endsequence

    sequence s_all_lost;
        s_track_auto ##0 !hold_mode && cur_lost && !any_valid;
    endsequence

    AST_NOREF_KEEP: assert property (@(posedge clock)
        disable iff (sys_rst)
        s_all_lost |=> $stable(sel_idx_q) && no_reference_q)
        else $error("selection moved with no valid input");

    AST_NOREF_EXIT: assert property (@(posedge clock)
        disable iff (sys_rst)
        auto_mode && state_q == RIS_ST_NOREF && any_valid
        |=> sel_idx_q == $past(best) && !no_reference_q)
        else $error("first valid input not taken");

    AST_HOLD_EXPIRE: assert property (@(posedge clock)
        disable iff (sys_rst)
        s_wait_lost ##0 hold_mode && expire && any_valid
        |=> sel_idx_q == $past(best) && state_q == RIS_ST_TRACK)
        else $error("fail-over at hold-off expiry missed");

    AST_WAIT_RECOVER: assert property (@(posedge clock)
        disable iff (sys_rst)
        auto_mode && state_q == RIS_ST_WAIT && !cur_lost
        |=> state_q == RIS_ST_TRACK && $stable(sel_idx_q))
        else $error("recovered input did not end the hold-off");

    AST_DIV4: assert property (@(posedge clock)
        disable iff (sys_rst)
        ctrl_q.monitor_prescale_select && pre_cnt_q != `RIS_PRESCALE_DIV4
        |=> !monitor_tick_out)
        else $error("divide by four passed an extra tick");

    AST_REVERTIVE_SWITCH_ENABLE_MANUAL: assert property (@(posedge clock)
        disable iff (sys_rst)
        !auto_mode && ctrl_q.revertive_switch_enable && revert_ev
        |=> sel_idx_q == $past(ctrl_q.manual_select))
        else $error("revertive switch acted in manual mode");

    AST_SEL_IGNORED: assert property (@(posedge clock)
        disable iff (sys_rst)
        s_track_auto ##0 !cur_lost && !revert_ev
        |=> $stable(sel_idx_q))
        else $error("manual select acted in automatic mode");

    AST_MODE_RSVD: assert property (@(posedge clock)
        disable iff (sys_rst)
        wr_go && word == `RIS_IDX_MODE |=> !ctrl_q.reserved
        && ctrl_q.selection_mode_field == $past(avs_writedata[3:2]))
        else $error("mode register write not stored");

    AST_INPUT_PRIORITY_WRITE: assert property (@(posedge clock)
        disable iff (sys_rst)
        wr_go && word == `RIS_IDX_INPUT_PRIORITY
        |=> input_priority_q == $past(avs_writedata[7:0]))
        else $error("priority write not stored");
endmodule : ris_selector

/* ris_src_model.sv */
// Model of the four reference sources feeding the input selector
`timescale 1ns/10ps
// ------------------------------------------------------------------
// Sources: loss flags and hold-off step pulses
// ------------------------------------------------------------------
module ris_src_model (
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic [3:0] lost,
    input  wire logic       tick_en,
    output logic      [3:0] los_in,
    output logic            holdoff_tick
);
    logic [1:0] div_q;
    // Flags and ticks leave on the edge, never mid-cycle
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            los_in       <= 4'h0;
            div_q        <= 2'h0;
            holdoff_tick <= 1'b0;
        end else begin
            los_in       <= lost;
            div_q        <= div_q + 2'h1;
            // Sparse ticks, one in four cycles, to keep counts short
            holdoff_tick <= tick_en && (div_q == 2'h3);
        end
    end
endmodule : ris_src_model

/* ris_tb.sv */
// Self-checking testbench of the reference input selector
`timescale 1ns/10ps
`include "ris_map.svh"
module testbench;
    logic        clock, sys_rst, avs_read, avs_write, monitor_tick;
    logic [7:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic        avs_waitrequest, monitor_tick_out, no_reference_q;
    logic [3:0]  lost, los_in;
    logic        tick_en, holdoff_tick;
    logic [1:0]  sel_idx_q;
    int          fails, num_checks, mon_cnt, tick_cnt;
    ris_selector dut (.clock(clock), .sys_rst(sys_rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .los_in(los_in), .holdoff_tick(holdoff_tick),
        .monitor_tick(monitor_tick), .monitor_tick_out(monitor_tick_out),
        .sel_idx_q(sel_idx_q), .no_reference_q(no_reference_q));
    ris_src_model src (.clock(clock), .sys_rst(sys_rst), .lost(lost),
        .tick_en(tick_en), .los_in(los_in), .holdoff_tick(holdoff_tick));
    // ------------------------------------------------------------------
    // Clock, counters, watchdog
    // ------------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    always @(posedge clock) begin
        if (monitor_tick_out === 1'b1) mon_cnt++;
        if (holdoff_tick === 1'b1) tick_cnt++;
    end
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        results;
    end
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
        num_checks++;
        if (seen !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, seen);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(posedge clock);
    endtask : cyc
    // Held until waitrequest is sampled low; one idle edge follows
    task bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
             output logic [31:0] q);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= {24'h0, d};
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clock);
    endtask : bus
    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(nm, q, e);
    endtask : rd
    task loss(input logic [3:0] v, input logic [1:0] e, input string nm);
        lost <= v;
        cyc(4);
        chk(nm, {30'h0, sel_idx_q}, {30'h0, e});
    endtask : loss
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task t_reset;
        rd(8'h50, {24'h0, `RIS_RST_INPUT_PRIORITY}, "input_priority");
        rd(8'h54, {24'h0, `RIS_RST_MODE}, "mode");
        rd(8'h58, {24'h0, `RIS_RST_HOLD}, "hold");
        rd(8'h5c, {24'h0, `RIS_RST_DIVPWR}, "divpwr");
        rd(8'h40, 32'h0, "unmapped");
        chk("sel", {30'h0, sel_idx_q}, 32'h0);
        $display("t_reset done");
    endtask : t_reset
    task t_manual;
        for (int i = 0; i < 4; i++) begin
            wr(8'h54, {6'h0, i[1:0]});
            cyc(2);
            chk("man sel", {30'h0, sel_idx_q}, i);
        end
        // Reserved bit must not stick
        wr(8'h54, 8'h89);
        rd(8'h54, 32'h09, "mode rb");
        chk("mode10 sel", {30'h0, sel_idx_q}, 32'h1);
        wr(8'h54, 8'h00);
        $display("t_manual done");
    endtask : t_manual
    task t_auto;
        wr(8'h50, 8'h1b);
        wr(8'h54, 8'h04);
        loss(4'h1, 2'h3, "auto best");
        loss(4'h9, 2'h2, "auto next");
        wr(8'h50, 8'h00);
        loss(4'h0, 2'h2, "no revert");
        $display("t_auto done");
    endtask : t_auto
    task t_revert;
        wr(8'h54, 8'h17);
        loss(4'h1, 2'h2, "keep cur");
        loss(4'h0, 2'h0, "revert tie");
        loss(4'h8, 2'h0, "low lost");
        loss(4'h0, 2'h0, "no outrank");
        wr(8'h54, 8'h1a);
        loss(4'h1, 2'h2, "man loss");
        loss(4'h0, 2'h2, "man revertive_switch_enable");
        $display("t_revert done");
    endtask : t_revert
    task t_prescale;
        logic [7:0] c;
        for (int k = 0; k < 2; k++) begin
            c = (k == 0) ? 8'h00 : 8'h20;
            wr(8'h54, c);
            mon_cnt = 0;
            repeat (8) begin
                monitor_tick <= 1'b1;
                @(posedge clock);
                monitor_tick <= 1'b0;
                cyc(2);
            end
            chk("prescale", mon_cnt, (k == 0) ? 8 : 2);
        end
        $display("t_prescale done");
    endtask : t_prescale
    task t_holdoff;
        wr(8'h50, 8'he4);
        wr(8'h58, 8'h03);
        wr(8'h54, 8'h0c);
        lost <= 4'h1;
        cyc(3);
        tick_cnt = 0;
        tick_en  <= 1'b1;
        while (tick_cnt < 2) @(posedge clock);
        cyc(2);
        chk("hold wait", {30'h0, sel_idx_q}, 32'h0);
        while (tick_cnt < 3) @(posedge clock);
        cyc(3);
        chk("hold fail", {30'h0, sel_idx_q}, 32'h1);
        tick_en <= 1'b0;
        loss(4'h2, 2'h1, "hold keep");
        rd(8'h60, 32'h12, "hold state");
        loss(4'h0, 2'h1, "hold back");
        $display("t_holdoff done");
    endtask : t_holdoff
    task t_noref;
        wr(8'h54, 8'h04);
        loss(4'hf, 2'h1, "noref keep");
        chk("noref set", {31'h0, no_reference_q}, 32'h1);
        rd(8'h60, 32'h3f, "noref state");
        loss(4'hb, 2'h2, "noref first");
        chk("noref clr", {31'h0, no_reference_q}, 32'h0);
        $display("t_noref done");
    endtask : t_noref
    task results;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 8'h00;
        avs_writedata = 32'h0;
        monitor_tick = 1'b0;
        lost = 4'h0;
        tick_en = 1'b0;
        cyc(20);
        sys_rst <= 1'b0;
        cyc(1);
        t_reset;
        t_manual;
        t_auto;
        t_revert;
        t_prescale;
        t_holdoff;
        t_noref;
        results;
    end
endmodule : testbench
